// [inc/metering_flags_consts.svh]
`ifndef METERING_FLAGS_CONSTS_SVH
`define METERING_FLAGS_CONSTS_SVH

`define ADDR_W 8
`define DATA_W 16
`define OFS_ENABLE 8'h64
`define OFS_FLAGS 8'h65
`define OFS_SIGNS 8'h66
`define OFS_BAND_STATUS 8'h68
`define ENABLE_RESET 16'h0000
`define FLAGS_RESET 16'h0000
`define SIGNS_RESET 16'h0000
`define BAND_RESET 3'h0
`define FLAG_MASK 16'hefff
`define BIT_OVER_LIMIT 15
`define BIT_VOLTAGE_DIP 14
`define BIT_BAND_CHANGE 13
`define BIT_SAMPLE_TICK 0
`define CLK_FREQ_HZ 100000000
`define SIGN_PERIOD_MS 250
`define SAMPLE_RATE_HZ 8000
`define SIGN_PERIOD_CYCLES (`CLK_FREQ_HZ / 1000 * `SIGN_PERIOD_MS)
`define SAMPLE_PERIOD_CYCLES (`CLK_FREQ_HZ / `SAMPLE_RATE_HZ)
`endif

// [inc/metering_flags_pkg.sv]
package metering_flags_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic over_limit;
    logic voltage_dip;
    logic [3:0] pulse_out;
    logic [6:0] crossing;
  } metering_events_type;

  typedef struct packed {
    logic [3:0] fund_reactive;
    logic [3:0] fund_active;
    logic [3:0] total_reactive;
    logic [3:0] total_active;
  } power_signs_type;

  typedef enum logic {
    WIRING_FOUR,
    WIRING_THREE
  } wiring_type;

endpackage : metering_flags_pkg

// [core/period_tick.sv]
`timescale 1ns/1ps
module period_tick #(
  parameter int unsigned PERIOD = 2
) (
  // Clock, reset and enable.
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Tick.
  output logic tick_out
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic wrap;

  assign wrap = (cnt_ff == 32'(PERIOD - 1));
  assign nxt_cnt = wrap ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cnt_ff <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  // One-cycle pulse once per period.
  assign tick_out = ce_in && wrap;

endmodule : period_tick

// [core/metering_event_flags.sv]
`timescale 1ns/1ps
`include "metering_flags_consts.svh"
module metering_event_flags #(
  parameter int unsigned SIGN_CYCLES = `SIGN_PERIOD_CYCLES,
  parameter int unsigned SAMPLE_CYCLES = `SAMPLE_PERIOD_CYCLES
) (
  // Clock, reset and enable.
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Mode and wiring.
  input wire logic metering_mode_in,
  input wire metering_flags_pkg::wiring_type wiring_in,
  // Metering events and levels.
  input wire metering_flags_pkg::metering_events_type events_in,
  input wire logic [2:0] band_level_in,
  input wire metering_flags_pkg::power_signs_type power_signs_in,
  // Register port.
  input wire metering_flags_pkg::reg_req_type req_in,
  output logic [15:0] rdata_out,
  // Phase status clears.
  output logic over_status_clr_out,
  output logic dip_status_clr_out,
  // Interrupt.
  output logic irq_out_n
);
  import metering_flags_pkg::*;

  logic [15:0] flags_ff;
  logic [15:0] nxt_flags;
  logic [15:0] enable_ff;
  logic [15:0] nxt_enable;
  power_signs_type signs_ff;
  logic [2:0] band_ff;
  logic [2:0] band_diff;
  logic [2:0] band_mask;
  logic band_change;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [15:0] rdata_ff;
  logic irq_n_ff;
  logic over_clr_ff;
  logic dip_clr_ff;
  logic sign_tick;
  logic sample_tick;
  logic wr_flags;
  logic wr_enable;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  period_tick #(
    .PERIOD(SIGN_CYCLES)
  ) u_sign_tick (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .tick_out(sign_tick)
  );

  period_tick #(
    .PERIOD(SAMPLE_CYCLES)
  ) u_sample_tick (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .tick_out(sample_tick)
  );

  assign wr_flags = req_in.wr && hit(req_in.addr, `OFS_FLAGS);
  assign wr_enable = req_in.wr && hit(req_in.addr, `OFS_ENABLE);

  // Band change compares new levels to the stored status on the slow tick.
  assign band_mask = (wiring_in == WIRING_THREE) ? 3'h5 : 3'h7;
  assign band_diff = band_level_in ^ band_ff;
  assign band_change = sign_tick && |(band_diff & band_mask);

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      band_ff <= `BAND_RESET;
    end
    else if (ce_in && sign_tick)
    begin
      band_ff <= band_level_in;
    end
  end

  // Events are only recorded in metering mode.
  always_comb
  begin
    set_vec = 16'h0000;
    if (metering_mode_in)
    begin
      set_vec[`BIT_OVER_LIMIT] = events_in.over_limit;
      set_vec[`BIT_VOLTAGE_DIP] = events_in.voltage_dip;
      set_vec[`BIT_BAND_CHANGE] = band_change;
      set_vec[11:8] = events_in.pulse_out;
      set_vec[7:1] = events_in.crossing;
      set_vec[`BIT_SAMPLE_TICK] = sample_tick;
    end
  end

  assign clr_vec = wr_flags ? (req_in.wdata & `FLAG_MASK) : 16'h0000;

  // A set arriving with a clear wins; a zero written leaves the bit.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_flag
      assign nxt_flags[gi] = set_vec[gi] || (flags_ff[gi] && !clr_vec[gi]);
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      flags_ff <= `FLAGS_RESET;
    end
    else if (ce_in)
    begin
      flags_ff <= nxt_flags;
    end
  end

  assign nxt_enable = wr_enable ? (req_in.wdata & `FLAG_MASK) : enable_ff;

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      enable_ff <= `ENABLE_RESET;
    end
    else if (ce_in)
    begin
      enable_ff <= nxt_enable;
    end
  end

  // The pin follows the flag and enable registers in the same edge.
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_n_ff <= 1'b1;
    end
    else if (ce_in)
    begin
      irq_n_ff <= ~|(nxt_flags & nxt_enable);
    end
  end

  assign irq_out_n = irq_n_ff;

  // Clearing the over-limit or dip flag also clears the matching phase status bits.
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      over_clr_ff <= 1'b0;
      dip_clr_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      over_clr_ff <= clr_vec[`BIT_OVER_LIMIT];
      dip_clr_ff <= clr_vec[`BIT_VOLTAGE_DIP];
    end
  end

  assign over_status_clr_out = over_clr_ff;
  assign dip_status_clr_out = dip_clr_ff;

  // Signs load only on the slow tick; the host cannot write them.
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      signs_ff <= `SIGNS_RESET;
    end
    else if (ce_in && sign_tick)
    begin
      signs_ff <= power_signs_in;
    end
  end

  // Read data is captured on a read strobe; unmapped offsets read zero.
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rdata_ff <= 16'h0000;
    end
    else if (ce_in && req_in.rd)
    begin
      if (hit(req_in.addr, `OFS_ENABLE))
      begin
        rdata_ff <= enable_ff;
      end
      else if (hit(req_in.addr, `OFS_FLAGS))
      begin
        rdata_ff <= flags_ff;
      end
      else if (hit(req_in.addr, `OFS_SIGNS))
      begin
        rdata_ff <= signs_ff;
      end
      else if (hit(req_in.addr, `OFS_BAND_STATUS))
      begin
        rdata_ff <= {13'h0, band_ff};
      end
      else
      begin
        rdata_ff <= 16'h0000;
      end
    end
  end

  assign rdata_out = rdata_ff;

  default clocking cb @(posedge sys_clk_in);
  endclocking

  default disable iff (!arst_n_in);

  sequence s_clear_over;
    ce_in && wr_flags && req_in.wdata[15] && !set_vec[15];
  endsequence

  sequence s_clear_dip;
    ce_in && wr_flags && req_in.wdata[14] && !set_vec[14];
  endsequence

  sequence s_idle_write_zero;
    ce_in && wr_flags && req_in.wdata == 16'h0000 && set_vec == 16'h0000;
  endsequence

  a_mode_gate: assert property (ce_in && !metering_mode_in |=>
    (flags_ff & ~$past(flags_ff)) == 16'h0000)
    else $error("Flag rose outside metering mode.");

  a_irq_follows: assert property (irq_out_n == ~|(flags_ff & enable_ff))
    else $error("Interrupt pin disagrees with enabled flags.");

  a_over_sets: assert property (ce_in && metering_mode_in && events_in.over_limit |=>
    flags_ff[15])
    else $error("Over-limit event did not set its flag.");

  a_over_clear: assert property (s_clear_over |=> !flags_ff[15] && over_status_clr_out)
    else $error("Over-limit clear failed.");

  a_dip_sets: assert property (ce_in && metering_mode_in && events_in.voltage_dip |=>
    flags_ff[14])
    else $error("Dip event did not set its flag.");

  a_dip_clear: assert property (s_clear_dip |=> !flags_ff[14] && dip_status_clr_out)
    else $error("Dip clear failed.");

  a_band_four: assert property (ce_in && metering_mode_in && sign_tick &&
    wiring_in == WIRING_FOUR && band_diff != 3'h0 |=> flags_ff[13])
    else $error("Four-wire band change not flagged.");

  a_band_three: assert property (ce_in && sign_tick && wiring_in == WIRING_THREE &&
    band_diff == 3'h2 && !flags_ff[13] |=> !flags_ff[13])
    else $error("Phase B band change flagged in three-wire mode.");

  a_band_status: assert property (ce_in && sign_tick |=> band_ff == $past(band_level_in))
    else $error("Band status not refreshed.");

  a_events_set: assert property (ce_in && metering_mode_in |=>
    (flags_ff & $past(set_vec)) == $past(set_vec))
    else $error("Event flag not set.");

  a_sign_hold: assert property (!(ce_in && sign_tick) |=> $stable(signs_ff))
    else $error("Signs changed off the update tick.");

  a_sign_load: assert property (ce_in && sign_tick |=>
    signs_ff == $past(power_signs_in))
    else $error("Signs not loaded on the update tick.");

  a_enable_reserved: assert property (enable_ff[12] == 1'b0)
    else $error("Reserved enable bit set.");

  a_zero_keeps: assert property (s_idle_write_zero |=> $stable(flags_ff))
    else $error("Writing zero changed the flags.");

  // A low clock enable holds every register and the pin.
  a_ce_freeze: assert property (!ce_in |=>
    $stable(flags_ff) && $stable(enable_ff) && $stable(signs_ff) && $stable(band_ff) && $stable(irq_out_n))
    else $error("State moved while the clock enable was low.");

  a_ce_pulses: assert property (!ce_in |=> $stable(over_status_clr_out) && $stable(dip_status_clr_out))
    else $error("Clear pulses moved while the clock enable was low.");

  a_flag_reserved: assert property (flags_ff[12] == 1'b0)
    else $error("Reserved flag bit set.");

  sequence s_band_three_ac;
    ce_in && metering_mode_in && sign_tick && wiring_in == WIRING_THREE && (band_diff & 3'h5) != 3'h0;
  endsequence

  a_band_three_ac: assert property (s_band_three_ac |=> flags_ff[13])
    else $error("Three-wire band change on phase A or C not flagged.");

  a_band_quiet: assert property (ce_in && !band_change && !flags_ff[13] |=> !flags_ff[13])
    else $error("Band flag rose without a band change.");

  a_w1c_clears: assert property (ce_in && wr_flags |=>
    (flags_ff & $past(clr_vec) & ~$past(set_vec)) == 16'h0000)
    else $error("Written one did not clear its flag.");

  a_over_quiet: assert property (ce_in && !(wr_flags && req_in.wdata[15]) |=> !over_status_clr_out)
    else $error("Over-limit status clear without a write.");

  a_dip_quiet: assert property (ce_in && !(wr_flags && req_in.wdata[14]) |=> !dip_status_clr_out)
    else $error("Dip status clear without a write.");

  a_irq_held: assert property (ce_in && !irq_out_n && !wr_flags && !wr_enable |=> !irq_out_n)
    else $error("Interrupt released with enabled flags still set.");

  a_enable_write: assert property (ce_in && wr_enable |=>
    enable_ff == ($past(req_in.wdata) & `FLAG_MASK))
    else $error("Enable write did not land.");

  a_enable_hold: assert property (ce_in && !wr_enable |=> $stable(enable_ff))
    else $error("Enable register changed without a write.");

  a_rd_flags: assert property (ce_in && req_in.rd && hit(req_in.addr, `OFS_FLAGS) |=>
    rdata_out == $past(flags_ff))
    else $error("Flag read returned the wrong value.");

  a_rd_signs: assert property (ce_in && req_in.rd && hit(req_in.addr, `OFS_SIGNS) |=>
    rdata_out == $past(signs_ff))
    else $error("Sign read returned the wrong value.");

  a_rd_enable: assert property (ce_in && req_in.rd && hit(req_in.addr, `OFS_ENABLE) |=>
    rdata_out == $past(enable_ff))
    else $error("Enable read returned the wrong value.");

  a_rd_band: assert property (ce_in && req_in.rd && hit(req_in.addr, `OFS_BAND_STATUS) |=>
    rdata_out == {13'h0, $past(band_ff)})
    else $error("Band status read returned the wrong value.");

  a_rd_hold: assert property (!(ce_in && req_in.rd) |=> $stable(rdata_out))
    else $error("Read data changed without a read.");

endmodule : metering_event_flags

// [test/metering_host_model.sv]
`timescale 1ns/1ps
module metering_host_model
(
  // Clock.
  input wire logic sys_clk_in,
  // Register port.
  input wire logic [15:0] rdata_in,
  output metering_flags_pkg::reg_req_type req_out
);
  import metering_flags_pkg::*;

  initial req_out = '0;

  // Holds the write strobe for exactly one taken edge.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk_in);
    #1 req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge sys_clk_in);
    #1 req_out.wr = 1'b0;
  endtask : wr_reg

  // Read data is registered, so it is settled just after the taken edge.
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk_in);
    #1 req_out = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(posedge sys_clk_in);
    #1 req_out.rd = 1'b0;
    v = rdata_in;
  endtask : rd_reg
endmodule : metering_host_model

// [test/metering_event_flags_and_power_signs_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module metering_event_flags_and_power_signs_tb;
  import metering_flags_pkg::*;

  logic sys_clk_in;
  logic arst_n_in;
  logic ce;
  logic metering_mode_in;
  wiring_type wiring_in;
  metering_events_type events_in;
  logic [2:0] band_level_in;
  power_signs_type power_signs_in;
  reg_req_type req;
  logic [15:0] rdata;
  logic over_clr;
  logic dip_clr;
  logic irq_out_n;
  logic [15:0] d;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  metering_event_flags #(.SIGN_CYCLES(20), .SAMPLE_CYCLES(7)) DUT (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
    .metering_mode_in(metering_mode_in), .wiring_in(wiring_in), .events_in(events_in),
    .band_level_in(band_level_in), .power_signs_in(power_signs_in), .req_in(req),
    .rdata_out(rdata), .over_status_clr_out(over_clr), .dip_status_clr_out(dip_clr),
    .irq_out_n(irq_out_n));

  metering_host_model HOST (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .req_out(req));

  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Raises the given events for one clock.
  task automatic fire(input logic [12:0] ev);
    @(posedge sys_clk_in);
    #1 events_in = ev;
    @(posedge sys_clk_in);
    #1 events_in = '0;
  endtask : fire

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : wait_cyc

  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    arst_n_in = 1'b0;
    ce = 1'b1;
    metering_mode_in = 1'b1;
    wiring_in = WIRING_FOUR;
    events_in = '0;
    band_level_in = 3'h0;
    power_signs_in = '0;
    wait_cyc(8);
    arst_n_in = 1'b1;
    `CHK(irq_out_n, 1'b1)
    HOST.rd_reg(8'h64, d);
    `CHK(d, 16'h0000)
    HOST.wr_reg(8'h64, 16'hffff);
    HOST.rd_reg(8'h64, d);
    `CHK(d, 16'hefff)
    HOST.wr_reg(8'h64, 16'h0000);
    fire(13'h1fff);
    HOST.rd_reg(8'h65, d);
    `CHK(d & 16'hfffe, 16'hcffe)
    HOST.wr_reg(8'h65, 16'h0000);
    HOST.rd_reg(8'h65, d);
    `CHK(d & 16'hfffe, 16'hcffe)
    HOST.wr_reg(8'h65, 16'h8000);
    `CHK(over_clr, 1'b1)
    `CHK(dip_clr, 1'b0)
    HOST.wr_reg(8'h65, 16'h4000);
    `CHK(dip_clr, 1'b1)
    HOST.rd_reg(8'h65, d);
    `CHK(d & 16'hfffe, 16'h0ffe)
    HOST.wr_reg(8'h65, 16'h0ffe);
    HOST.rd_reg(8'h65, d);
    `CHK(d & 16'hfffe, 16'h0000)
    `CHK(d[0], 1'b1)
    metering_mode_in = 1'b0;
    fire(13'h1ffe);
    HOST.rd_reg(8'h65, d);
    `CHK(d & 16'hfffe, 16'h0000)
    metering_mode_in = 1'b1;
    HOST.wr_reg(8'h64, 16'h0100);
    wait_cyc(1);
    `CHK(irq_out_n, 1'b1)
    fire(13'h0080);
    wait_cyc(2);
    `CHK(irq_out_n, 1'b0)
    HOST.wr_reg(8'h65, 16'h0100);
    wait_cyc(1);
    `CHK(irq_out_n, 1'b1)
    HOST.wr_reg(8'h64, 16'h0001);
    HOST.wr_reg(8'h65, 16'h0001);
    `CHK(irq_out_n, 1'b1)
    wait_cyc(8);
    `CHK(irq_out_n, 1'b0)
    HOST.wr_reg(8'h64, 16'h0000);
    power_signs_in = '{4'h8, 4'h1, 4'h2, 4'h4};
    wiring_in = WIRING_THREE;
    band_level_in = 3'h2;
    wait_cyc(7);
    HOST.rd_reg(8'h66, d);
    `CHK(d, 16'h8124)
    HOST.wr_reg(8'h66, 16'h0000);
    HOST.rd_reg(8'h66, d);
    `CHK(d, 16'h8124)
    HOST.rd_reg(8'h65, d);
    `CHK(d & 16'h2000, 16'h0000)
    HOST.rd_reg(8'h68, d);
    `CHK(d, 16'h0002)
    wiring_in = WIRING_FOUR;
    band_level_in = 3'h0;
    wait_cyc(21);
    HOST.rd_reg(8'h65, d);
    `CHK(d & 16'h2000, 16'h2000)
    HOST.wr_reg(8'h64, 16'h2000);
    wait_cyc(1);
    `CHK(irq_out_n, 1'b0)
    HOST.wr_reg(8'h65, 16'h2000);
    wait_cyc(1);
    `CHK(irq_out_n, 1'b1)
    ce = 1'b0;
    fire(13'h0040);
    ce = 1'b1;
    HOST.rd_reg(8'h65, d);
    `CHK(d & 16'h0080, 16'h0000)
    HOST.wr_reg(8'h65, 16'h0000);
    HOST.rd_reg(8'h65, d);
    `CHK(d, 16'h0001)
    end_sim();
  end
endmodule : metering_event_flags_and_power_signs_tb
